// File: rtl/isc_pkg.sv
// Shared constants, carrier structs and states of the interrupt source channel map
package isc_pkg;
    localparam int NUM_CH = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int AXI_AW = 8;
    localparam int SWI_W  = 1;

    // Request channel numbers
    localparam int CH_WDT   = 0;
    localparam int CH_SWI   = 1;
    localparam int CH_TMR0  = 4;
    localparam int CH_TMR1  = 5;
    localparam int CH_UART0 = 6;
    localparam int CH_UART1 = 7;
    localparam int CH_PWM   = 8;
    localparam int CH_SPI0  = 10;
    localparam int CH_SPI1  = 11;
    localparam int CH_RTC   = 13;
    localparam int CH_EXT0  = 14;
    localparam int CH_ACC   = 19;
    localparam int CH_CAN0  = 20;
    localparam int CH_LAST  = 27;

    // Flag counts per source
    localparam int TMR_N      = 4;
    localparam int TMR_FLAG_N = 2 * TMR_N;
    localparam int LSR_SRC_N  = 4;
    localparam int UART0_N    = 4;
    localparam int UART1_N    = 5;
    localparam int PWM_N      = 7;
    localparam int SPI_N      = 2;
    localparam int SYNC_N     = 4;
    localparam int RTC_N      = 2;
    localparam int EXT_N      = 4;
    localparam int CAN_N      = 4;

    // Register byte offsets, reset values and responses
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
    localparam logic [AXI_AW-1:0] REG_MASK   = 8'h04;
    localparam logic [AXI_AW-1:0] REG_REQ    = 8'h08;
    localparam logic [AXI_AW-1:0] REG_SWINT  = 8'h0c;
    localparam logic [NUM_CH-1:0] MASK_RST   = 32'h0000_0000;
    localparam logic [SWI_W-1:0]  SWINT_RST  = 1'h0;
    localparam logic [1:0]        RESP_OKAY  = 2'h0;
    localparam logic [1:0]        RESP_SLV   = 2'h2;

    typedef struct packed {
        logic [TMR_N-1:0] match_flag;
        logic [TMR_N-1:0] capture_flag;
    } isc_tmr_t;

    typedef struct packed {
        logic [LSR_SRC_N-1:0] rx_line_status_src;
        logic                 tx_holding_empty_flag;
        logic                 rx_data_available_flag;
        logic                 char_timeout_flag;
        logic                 modem_status_flag;
    } isc_uart_t;

    typedef struct packed {
        logic serial_xfer_done_flag;
        logic serial_mode_fault_flag;
    } isc_spi_t;

    typedef struct packed {
        logic sync_tx_raw_flag;
        logic sync_rx_raw_flag;
        logic sync_rx_timeout_raw_flag;
        logic sync_rx_overrun_raw_flag;
    } isc_sync_t;

    typedef struct packed {
        logic             watchdog_irq_flag;
        isc_tmr_t         tmr0;
        isc_tmr_t         tmr1;
        isc_uart_t        uart0;
        isc_uart_t        uart1;
        logic [PWM_N-1:0] pwm_match_flag;
        isc_spi_t         spi0;
        isc_spi_t         spi1;
        isc_sync_t        sync_serial_port;
        logic             clock_counter_increment_flag;
        logic             clock_alarm_flag;
        logic [EXT_N-1:0] external_irq;
        logic             accept_filter_flag;
        logic [CAN_N-1:0] can_tx_flag;
        logic [CAN_N-1:0] can_rx_flag;
    } isc_src_t;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } isc_axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } isc_axil_rsp_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RESP = 1'b1
    } isc_bus_st_t;
endpackage

// File: rtl/isc_flag_merge.sv
// Combines a group of interrupt flags into one request line
module isc_flag_merge #(
    parameter int N = 2
) (
    input  wire logic [N-1:0] flags_in,
    output logic              line_out
);
    // Any active flag raises the line
    assign line_out = |flags_in;
endmodule

// File: rtl/isc_sticky_bank.sv
// Sticky event status bits with mask and one level interrupt
module isc_sticky_bank #(
    parameter int W = 32
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] event_in,
    input  wire logic [W-1:0] clear_in,
    input  wire logic [W-1:0] mask_in,
    output logic [W-1:0]      status_out,
    output logic              irq_out
);
    logic [W-1:0] status_r;
    logic         irq_r;

    for (genvar i = 0; i < W; i++) begin : g_bit
        // Set beats clear so an event in the clearing cycle is kept
        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                status_r[i] <= 1'b0;
            end else if (event_in[i]) begin
                status_r[i] <= 1'b1;
            end else if (clear_in[i]) begin
                status_r[i] <= 1'b0;
            end
        end

        sequence s_hit;
            event_in[i] && mask_in[i];
        endsequence

        sequence s_raise;
            status_out[i] ##1 irq_out;
        endsequence

        AST_STICKY_IRQ: assert property (@(posedge clk_in) disable iff (!rstn_in)
            s_hit ##1 mask_in[i] |-> s_raise)
            else $error("unmasked event did not raise interrupt");
        AST_W1C: assert property (@(posedge clk_in) disable iff (!rstn_in)
            clear_in[i] && !event_in[i] |=> !status_out[i])
            else $error("write one did not clear status bit");
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_in);
        end
    end

    assign status_out = status_r;
    assign irq_out    = irq_r;
endmodule

// File: rtl/isc_channel_map.sv
// Interrupt source to request channel map with AXI4-Lite status and mask
// Summary of operation
// - Each peripheral offers one request line (each bus controller offers two), high while any of its flags is high (first serial port's modem flag unused).
// - A flag fed by several event sources is high while any of those sources is high.
// - The watchdog flag drives channel 0, and channel 1 is driven only by software.
// - Both timers' four match and four capture flags combine onto channels 4 and 5.
// - First serial port flags drive channel 6; the second adds modem status on channel 7.
// - The seven pulse-width match flags combine onto channel 8.
// - First serial interface drives 10; second interface and sync serial port share 11.
// - The clock increment and alarm flags combine onto channel 13.
// - External inputs zero to three drive channels 14 to 17 in order.
// - The shared acceptance filter drives channel 19.
// - Each bus controller drives transmit then receive on pairs 20,21 through 26,27.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
module isc_channel_map (
    input  wire logic                   clk_in,
    input  wire logic                   rstn_in,
    input  wire isc_pkg::isc_src_t      src_in,
    input  wire isc_pkg::isc_axil_req_t axi_in,
    output isc_pkg::isc_axil_rsp_t      axi_out,
    output logic [isc_pkg::NUM_CH-1:0]  chan_req_out,
    output logic                        irq_out
);
    import isc_pkg::*;

    logic [NUM_CH-1:0] req_nxt;
    logic [NUM_CH-1:0] req_r;
    logic [NUM_CH-1:0] prev_r;
    logic [NUM_CH-1:0] evt;
    logic [NUM_CH-1:0] status;
    logic [NUM_CH-1:0] mask_r;
    logic [NUM_CH-1:0] clr_vec;
    logic [SWI_W-1:0]  swint_r;

    logic tmr0_line;
    logic tmr1_line;
    logic uart0_lsr;
    logic uart1_lsr;
    logic uart0_line;
    logic uart1_line;
    logic pwm_line;
    logic spi0_line;
    logic spi1_line;
    logic rtc_line;

    // Bus side state
    isc_bus_st_t       wr_st_r;
    isc_bus_st_t       rd_st_r;
    logic              aw_hold_r;
    logic [AXI_AW-1:0] aw_addr_r;
    logic              w_hold_r;
    logic [DATA_W-1:0] w_data_r;
    logic [STRB_W-1:0] w_strb_r;
    logic [DATA_W-1:0] wmask;
    logic              wr_fire;
    logic              wr_hit;
    logic [1:0]        bresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic [1:0]        rd_resp_nxt;

    // Per peripheral request lines
    isc_flag_merge #(.N(TMR_FLAG_N)) u_tmr0 (
        .flags_in (src_in.tmr0),
        .line_out (tmr0_line)
    );

    isc_flag_merge #(.N(TMR_FLAG_N)) u_tmr1 (
        .flags_in (src_in.tmr1),
        .line_out (tmr1_line)
    );

    // Line status flag has several error sources of its own
    isc_flag_merge #(.N(LSR_SRC_N)) u_lsr0 (
        .flags_in (src_in.uart0.rx_line_status_src),
        .line_out (uart0_lsr)
    );

    isc_flag_merge #(.N(LSR_SRC_N)) u_lsr1 (
        .flags_in (src_in.uart1.rx_line_status_src),
        .line_out (uart1_lsr)
    );

    // First port has no modem lines, so its modem bit is not used
    isc_flag_merge #(.N(UART0_N)) u_uart0 (
        .flags_in ({uart0_lsr,
                    src_in.uart0.tx_holding_empty_flag,
                    src_in.uart0.rx_data_available_flag,
                    src_in.uart0.char_timeout_flag}),
        .line_out (uart0_line)
    );

    isc_flag_merge #(.N(UART1_N)) u_uart1 (
        .flags_in ({uart1_lsr,
                    src_in.uart1.tx_holding_empty_flag,
                    src_in.uart1.rx_data_available_flag,
                    src_in.uart1.char_timeout_flag,
                    src_in.uart1.modem_status_flag}),
        .line_out (uart1_line)
    );

    isc_flag_merge #(.N(PWM_N)) u_pwm (
        .flags_in (src_in.pwm_match_flag),
        .line_out (pwm_line)
    );

    isc_flag_merge #(.N(SPI_N)) u_spi0 (
        .flags_in (src_in.spi0),
        .line_out (spi0_line)
    );

    // Second interface and sync port share pins, so they share a channel
    isc_flag_merge #(.N(SPI_N + SYNC_N)) u_spi1 (
        .flags_in ({src_in.spi1, src_in.sync_serial_port}),
        .line_out (spi1_line)
    );

    isc_flag_merge #(.N(RTC_N)) u_rtc (
        .flags_in ({src_in.clock_counter_increment_flag, src_in.clock_alarm_flag}),
        .line_out (rtc_line)
    );

    // Channel assembly
    always_comb begin
        req_nxt = '0;
        req_nxt[CH_WDT]   = src_in.watchdog_irq_flag;
        req_nxt[CH_SWI]   = swint_r[0];
        req_nxt[CH_TMR0]  = tmr0_line;
        req_nxt[CH_TMR1]  = tmr1_line;
        req_nxt[CH_UART0] = uart0_line;
        req_nxt[CH_UART1] = uart1_line;
        req_nxt[CH_PWM]   = pwm_line;
        req_nxt[CH_SPI0]  = spi0_line;
        req_nxt[CH_SPI1]  = spi1_line;
        req_nxt[CH_RTC]   = rtc_line;
        for (int i = 0; i < EXT_N; i++) begin
            req_nxt[CH_EXT0 + i] = src_in.external_irq[i];
        end
        req_nxt[CH_ACC] = src_in.accept_filter_flag;
        for (int i = 0; i < CAN_N; i++) begin
            req_nxt[CH_CAN0 + 2 * i]     = src_in.can_tx_flag[i];
            req_nxt[CH_CAN0 + 2 * i + 1] = src_in.can_rx_flag[i];
        end
    end

    // One register stage keeps the controller inputs glitch free
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            prev_r <= '0;
        end else begin
            prev_r <= req_r;
        end
    end

    assign chan_req_out = req_r;

    // A rising request is an event for the status register
    assign evt = req_r & ~prev_r;

    isc_sticky_bank #(.W(NUM_CH)) u_sticky (
        .clk_in     (clk_in),
        .rstn_in    (rstn_in),
        .event_in   (evt),
        .clear_in   (clr_vec),
        .mask_in    (mask_r),
        .status_out (status),
        .irq_out    (irq_out)
    );

    // Write channel: address and data are taken in either order
    for (genvar b = 0; b < STRB_W; b++) begin : g_strb
        assign wmask[8 * b +: 8] = {8{w_strb_r[b]}};
    end

    assign wr_fire = (wr_st_r == ST_IDLE) && aw_hold_r && w_hold_r;
    assign wr_hit  = (aw_addr_r == REG_STATUS) || (aw_addr_r == REG_MASK) ||
                     (aw_addr_r == REG_REQ) || (aw_addr_r == REG_SWINT);
    assign clr_vec = (wr_fire && aw_addr_r == REG_STATUS) ? (w_data_r & wmask) : '0;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (axi_in.awvalid && axi_out.awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= axi_in.awaddr;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            w_hold_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (axi_in.wvalid && axi_out.wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= axi_in.wdata;
            w_strb_r <= axi_in.wstrb;
        end else if (wr_fire) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wr_st_r <= ST_IDLE;
            bresp_r <= RESP_OKAY;
        end else begin
            case (wr_st_r)
                ST_IDLE: begin
                    if (wr_fire) begin
                        wr_st_r <= ST_RESP;
                        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLV;
                    end
                end
                default: begin
                    if (axi_in.bready) begin
                        wr_st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Writable registers honour byte strobes
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mask_r <= MASK_RST;
        end else if (wr_fire && aw_addr_r == REG_MASK) begin
            mask_r <= (mask_r & ~wmask) | (w_data_r & wmask);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            swint_r <= SWINT_RST;
        end else if (wr_fire && aw_addr_r == REG_SWINT && w_strb_r[0]) begin
            swint_r <= w_data_r[SWI_W-1:0];
        end
    end

    // Read channel
    always_comb begin
        rd_data_nxt = '0;
        rd_resp_nxt = RESP_OKAY;
        if (axi_in.araddr == REG_STATUS) begin
            rd_data_nxt = status;
        end else if (axi_in.araddr == REG_MASK) begin
            rd_data_nxt = mask_r;
        end else if (axi_in.araddr == REG_REQ) begin
            rd_data_nxt = req_r;
        end else if (axi_in.araddr == REG_SWINT) begin
            rd_data_nxt[SWI_W-1:0] = swint_r;
        end else begin
            rd_resp_nxt = RESP_SLV;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rd_st_r <= ST_IDLE;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            case (rd_st_r)
                ST_IDLE: begin
                    if (axi_in.arvalid) begin
                        rd_st_r <= ST_RESP;
                        rdata_r <= rd_data_nxt;
                        rresp_r <= rd_resp_nxt;
                    end
                end
                default: begin
                    if (axi_in.rready) begin
                        rd_st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        axi_out.awready = (wr_st_r == ST_IDLE) && !aw_hold_r;
        axi_out.wready  = (wr_st_r == ST_IDLE) && !w_hold_r;
        axi_out.bvalid  = (wr_st_r == ST_RESP);
        axi_out.bresp   = bresp_r;
        axi_out.arready = (rd_st_r == ST_IDLE);
        axi_out.rvalid  = (rd_st_r == ST_RESP);
        axi_out.rdata   = rdata_r;
        axi_out.rresp   = rresp_r;
    end

    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    AST_PERIPH_LINE: assert property ($past(rstn_in) |->
        chan_req_out[CH_SPI0] == $past(|src_in.spi0))
        else $error("first interface line does not follow its flags");

    AST_LSR_SOURCES: assert property ((|src_in.uart0.rx_line_status_src) |=>
        chan_req_out[CH_UART0])
        else $error("line status source did not raise channel");

    AST_WDT_CHANNEL: assert property ($past(rstn_in) |->
        chan_req_out[CH_WDT] == $past(src_in.watchdog_irq_flag))
        else $error("watchdog channel mismatch");

    AST_SWI_CHANNEL: assert property ($past(rstn_in) |->
        chan_req_out[CH_SWI] == $past(swint_r[0]))
        else $error("software channel mismatch");

    AST_TIMER_CHANNELS: assert property ($past(rstn_in) |->
        chan_req_out[CH_TMR0] == $past(|src_in.tmr0) &&
        chan_req_out[CH_TMR1] == $past(|src_in.tmr1))
        else $error("timer channel mismatch");

    AST_UART_CHANNELS: assert property ($past(rstn_in) |->
        chan_req_out[CH_UART0] == $past(|src_in.uart0[$bits(isc_uart_t)-1:1]) &&
        chan_req_out[CH_UART1] == $past(|src_in.uart1))
        else $error("serial port channel mismatch");

    AST_PWM_CHANNEL: assert property ($past(rstn_in) |->
        chan_req_out[CH_PWM] == $past(|src_in.pwm_match_flag))
        else $error("pwm channel mismatch");

    AST_SHARED_CHANNEL: assert property ($past(rstn_in) |->
        chan_req_out[CH_SPI1] == $past(|{src_in.spi1, src_in.sync_serial_port}))
        else $error("shared serial channel mismatch");

    AST_RTC_CHANNEL: assert property ($past(rstn_in) |->
        chan_req_out[CH_RTC] == $past(src_in.clock_counter_increment_flag | src_in.clock_alarm_flag))
        else $error("clock channel mismatch");

    AST_EXT_CHANNELS: assert property ($past(rstn_in) |->
        chan_req_out[CH_EXT0 +: EXT_N] == $past(src_in.external_irq))
        else $error("external channel mismatch");

    AST_ACC_CHANNEL: assert property ($past(rstn_in) |->
        chan_req_out[CH_ACC] == $past(src_in.accept_filter_flag))
        else $error("acceptance filter channel mismatch");

    AST_CAN_PAIRS: assert property ($past(rstn_in) |->
        chan_req_out[CH_CAN0] == $past(src_in.can_tx_flag[0]) &&
        chan_req_out[CH_LAST] == $past(src_in.can_rx_flag[CAN_N-1]))
        else $error("bus controller pair mismatch");

    AST_UNUSED_LOW: assert property (chan_req_out[NUM_CH-1:CH_LAST+1] == '0 &&
        !chan_req_out[2] && !chan_req_out[3] && !chan_req_out[9] &&
        !chan_req_out[12] && !chan_req_out[18])
        else $error("unsourced channel active");

    AST_BVALID_HOLD: assert property (axi_out.bvalid && !axi_in.bready |=> axi_out.bvalid)
        else $error("write response dropped before ready");
endmodule

// File: bench/isc_vic_model.sv
// Far-side model: vectored controller latching raised request channels
module isc_vic_model
    import isc_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              ack_in,
    input  wire logic [NUM_CH-1:0] req_in,
    output logic [NUM_CH-1:0]      pend_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Held until acknowledged, so a one-cycle request is kept unless it comes in the ack_in cycle
    always @(posedge clk_in) begin
        if (!rstn_in || ack_in) begin
            pend_out <= '0;
        end else begin
            pend_out <= pend_out | req_in;
        end
    end
endmodule

// File: bench/isc_channel_map_bench.sv
// Self-checking bench of the interrupt source channel map
module isc_channel_map_bench
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_in = 1'b0;
    logic              rstn_in = 1'b0;
    logic              ack = 1'b0;
    isc_src_t          src = '0;
    isc_axil_req_t     rq = '0;
    isc_axil_rsp_t     rs;
    logic [NUM_CH-1:0] chan;
    logic [NUM_CH-1:0] pend;
    logic              irq;
    int                fail_count = 0;
    int                checks = 0;
    logic [3:0]        strb = 4'hf;

    always #50 clk_in = ~clk_in;

    isc_channel_map dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .src_in(src), .axi_in(rq),
        .axi_out(rs), .chan_req_out(chan), .irq_out(irq));
    isc_vic_model ctl_u (.clk_in(clk_in), .rstn_in(rstn_in), .ack_in(ack), .req_in(chan),
        .pend_out(pend));

    function automatic logic [NUM_CH-1:0] exp_chan(isc_src_t s, logic sw);
        logic [NUM_CH-1:0] v;
        v = '0;
        v[CH_WDT] = s.watchdog_irq_flag;
        v[CH_SWI] = sw;
        v[CH_TMR0] = |s.tmr0;
        v[CH_TMR1] = |s.tmr1;
        // First serial port has no modem status
        v[CH_UART0] = |s.uart0[7:1];
        v[CH_UART1] = |s.uart1;
        v[CH_PWM] = |s.pwm_match_flag;
        v[CH_SPI0] = |s.spi0;
        v[CH_SPI1] = |{s.spi1, s.sync_serial_port};
        v[CH_RTC] = s.clock_counter_increment_flag | s.clock_alarm_flag;
        v[CH_EXT0+:EXT_N] = s.external_irq;
        v[CH_ACC] = s.accept_filter_flag;
        for (int i = 0; i < CAN_N; i++) begin
            v[CH_CAN0+2*i] = s.can_tx_flag[i];
            v[CH_CAN0+2*i+1] = s.can_rx_flag[i];
        end
        return v;
    endfunction

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
        logic ta;
        logic tw;
        logic a1;
        logic w1;
        @(posedge clk_in);
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= d;
        rq.wstrb <= strb;
        rq.bready <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        // Each channel is released only at the edge that takes it
        while (!(ta && tw)) begin
            @(negedge clk_in);
            a1 = rq.awvalid && rs.awready;
            w1 = rq.wvalid && rs.wready;
            @(posedge clk_in);
            if (a1) rq.awvalid <= 1'b0;
            if (w1) rq.wvalid <= 1'b0;
            ta |= a1;
            tw |= w1;
        end
        do @(negedge clk_in); while (rs.bvalid !== 1'b1);
        rsp = rs.bresp;
        @(posedge clk_in);
        rq.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
        @(posedge clk_in);
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        rq.rready <= 1'b1;
        do @(negedge clk_in); while (rs.arready !== 1'b1);
        @(posedge clk_in);
        rq.arvalid <= 1'b0;
        do @(negedge clk_in); while (rs.rvalid !== 1'b1);
        d = rs.rdata;
        rsp = rs.rresp;
        @(posedge clk_in);
        rq.rready <= 1'b0;
    endtask

    // Sources go in at one edge, the vector is looked at after the next
    task automatic step(input isc_src_t s);
        @(posedge clk_in);
        src <= s;
        @(posedge clk_in);
        #1;
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        logic [31:0]       d;
        logic [1:0]        rsp;
        logic [63:0]       r;
        isc_src_t          s;
        logic [NUM_CH-1:0] acc;
        void'($urandom(32'h5280888f));
        acc = '0;
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        chk("chan_rst", chan, '0);
        chk("irq_rst", {31'h0, irq}, '0);
        rd(REG_MASK, d, rsp);
        chk("mask_rst", d, MASK_RST);
        for (int b = 0; b < $bits(isc_src_t); b++) begin
            r = 64'h1 << b;
            s = r[$bits(isc_src_t)-1:0];
            step(s);
            acc |= exp_chan(s, 1'b0);
            chk("chan_hot", chan, exp_chan(s, 1'b0));
        end
        step('0);
        chk("ctl_pend", pend, acc);
        ack <= 1'b1;
        @(posedge clk_in);
        ack <= 1'b0;
        repeat (200) begin
            r = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
            s = r[$bits(isc_src_t)-1:0];
            step(s);
            chk("chan_rnd", chan, exp_chan(s, 1'b0));
        end
        wr(REG_SWINT, 32'h1, rsp);
        step('0);
        chk("chan_swi", chan, exp_chan('0, 1'b1));
        rd(REG_SWINT, d, rsp);
        chk("swint_rd", d, 32'h1);
        wr(REG_SWINT, 32'h0, rsp);
        step('0);
        chk("chan_swi0", chan, '0);
        wr(REG_STATUS, 32'hffff_ffff, rsp);
        wr(REG_MASK, 32'h1 << (CH_EXT0 + 1), rsp);
        s = '0;
        s.external_irq = 4'h2;
        s.watchdog_irq_flag = 1'b1;
        step(s);
        step('0);
        chk("irq_set", {31'h0, irq}, 32'h1);
        rd(REG_STATUS, d, rsp);
        chk("status", d, 32'h0000_8001);
        wr(REG_MASK, 32'h0, rsp);
        @(posedge clk_in);
        #1;
        chk("irq_mask", {31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h0000_8000, rsp);
        wr(REG_STATUS, 32'h0000_8000, rsp);
        @(posedge clk_in);
        #1;
        chk("irq_clr", {31'h0, irq}, 32'h0);
        rd(REG_STATUS, d, rsp);
        chk("status_clr", d, 32'h1);
        s.external_irq = 4'h9;
        step(s);
        rd(REG_REQ, d, rsp);
        chk("req_reg", d, exp_chan(s, 1'b0));
        chk("req_rsp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        wr(8'h40, 32'hffff_ffff, rsp);
        chk("bad_wr", {30'h0, rsp}, {30'h0, RESP_SLV});
        rd(8'h40, d, rsp);
        chk("bad_rd", d, 32'h0);
        chk("bad_rsp", {30'h0, rsp}, {30'h0, RESP_SLV});
        // Unmapped write must leave the caught rising edges alone
        rd(REG_STATUS, d, rsp);
        chk("status_keep", d, 32'h0002_4001);
        wr(REG_REQ, 32'hffff_ffff, rsp);
        chk("req_wr", {30'h0, rsp}, {30'h0, RESP_OKAY});
        rd(REG_REQ, d, rsp);
        chk("req_keep", d, exp_chan(s, 1'b0));
        // Only byte lane one of the mask is written
        strb = 4'h2;
        wr(REG_MASK, 32'hffff_ffff, rsp);
        strb = 4'hf;
        rd(REG_MASK, d, rsp);
        chk("mask_lane", d, 32'h0000_ff00);
        chk("irq_lane", {31'h0, irq}, 32'h1);
        // Reset in mid-run with sources still high
        @(posedge clk_in);
        rstn_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("chan_rst2", chan, '0);
        chk("irq_rst2", {31'h0, irq}, '0);
        @(posedge clk_in);
        rstn_in <= 1'b1;
        step(s);
        chk("chan_rel", chan, exp_chan(s, 1'b0));
        rd(REG_MASK, d, rsp);
        chk("mask_rst2", d, MASK_RST);
        tally_and_finish;
    end
endmodule
